//--- verilog/icwc_idle_ctrl.sv
// Idle command decoder and wait-for-event wake controller
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module icwc_idle_ctrl (
  input  wire logic        clk_sys,        // System clock, 40 MHz
  input  wire logic        rst_n,          // Async reset, active low
  input  wire logic [7:0]  cmd_byte,       // Command byte from transport
  input  wire logic        cmd_valid,      // Command byte strobe
  output logic [7:0]       rsp_byte,       // Reply byte
  output logic             rsp_valid,      // Reply byte available
  input  wire logic        rsp_ready,      // Reply byte taken
  input  wire logic        lfo_clk_pin,    // Low frequency oscillator
  input  wire logic        field_det_pin,  // Field detector level
  input  wire logic        irq_in_n,       // Wake pin, low pulse
  input  wire logic        sel_n,          // Select pin, low pulse
  input  wire logic [7:0]  dac_level,      // Drive current measure
  input  wire logic        swing_pulse,    // One carrier swing done
  output logic             wait_mode,      // In wait-for-event mode
  output logic             hfo_enable,     // High frequency oscillator on
  output logic             dac_enable,     // Converter on
  output logic             burst_on,       // Detection burst active
  output logic [15:0]      res_word,       // Resource control word
  input  wire logic [7:0]  reg_addr,       // Register byte address
  input  wire logic [31:0] reg_wdata,      // Register write data
  input  wire logic        reg_wr,         // Register write strobe
  input  wire logic        reg_rd,         // Register read strobe
  output logic [31:0]      reg_rdata       // Read data, next cycle
);
  localparam int NB = icwc_pkg::PARAM_BYTES;

  icwc_pkg::icwc_state_t state, next_state;
  logic [7:0]  idx, next_idx, len, next_len, rsp_idx, next_rsp_idx;
  logic        have_len, next_have_len, err_flag, next_err_flag;
  logic [7:0]  frame_buf [NB];
  logic [7:0]  next_frame_buf [NB];
  logic [4:0]  wake_en, next_wake_en, wake_src, next_wake_src;
  logic [15:0] enter_word, next_enter_word, wait_word, next_wait_word;
  logic [15:0] leave_word, next_leave_word, next_res_word;
  logic [7:0]  interval, next_interval, osc_start, next_osc_start;
  logic [7:0]  dac_start, next_dac_start, cmp_lo, next_cmp_lo;
  logic [7:0]  cmp_hi, next_cmp_hi, swing_lim, next_swing_lim;
  logic [7:0]  trial_lim, next_trial_lim, swing_cnt, next_swing_cnt;
  logic [7:0]  next_rsp_byte;
  logic [4:0]  trial_cnt, next_trial_cnt;
  logic [31:0] next_rdata;
  logic [3:0]  pin_meta, pin_sync, pin_last;
  logic [7:0]  dac_meta, dac_sync;
  logic        lfo_tick, field_on, irq_fall, sel_fall, ext_hit;
  logic [4:0]  ext_src;
  logic        tmr_load, tmr_done, frame_end, tag_seen, trials_done;
  logic [icwc_pkg::TMR_W-1:0] tmr_val;

  // Interval wait: 256 slow periods times (coefficient + 2)
  function automatic logic [icwc_pkg::TMR_W-1:0] ivl_ticks(input logic [7:0] v);
    ivl_ticks = {({1'b0, v} + icwc_pkg::IVL_OFFSET), icwc_pkg::REF_LOW};
  endfunction

  // Reply byte by position
  function automatic logic [7:0] rsp_pick(input logic err, input logic [7:0] i,
                                          input logic [4:0] src);
    if (err) begin
      rsp_pick = (i == 8'h00) ? icwc_pkg::RSP_ERR : icwc_pkg::RSP_LEN0;
    end else if (i == 8'h00) begin
      rsp_pick = icwc_pkg::RSP_OK;
    end else if (i == 8'h01) begin
      rsp_pick = icwc_pkg::RSP_LEN1;
    end else begin
      rsp_pick = {3'h0, src};
    end
  endfunction

  // Two-stage synchronisers for pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 4'hC;  // Select and irq idle high, field and slow clock low
      pin_sync <= 4'hC;
      pin_last <= 4'hC;
      dac_meta <= 8'h00;
      dac_sync <= 8'h00;
    end else begin
      pin_meta <= {sel_n, irq_in_n, field_det_pin, lfo_clk_pin};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
      dac_meta <= dac_level;
      dac_sync <= dac_meta;
    end
  end

  // Slow tick and external wake events
  assign lfo_tick = pin_sync[0] & ~pin_last[0];
  assign field_on = pin_sync[1];
  assign irq_fall = pin_last[2] & ~pin_sync[2];
  assign sel_fall = pin_last[3] & ~pin_sync[3];
  assign ext_src  = sel_fall ? 5'h10 : irq_fall ? 5'h08 : 5'h04;
  assign ext_hit  = (sel_fall & wake_en[icwc_pkg::WB_SEL])
                  | (irq_fall & wake_en[icwc_pkg::WB_IRQ])
                  | (field_on & wake_en[icwc_pkg::WB_FIELD]);
  assign frame_end = cmd_valid && have_len && ((idx + 8'h01) == len);
  assign tag_seen  = (dac_sync < cmp_lo) || (dac_sync > cmp_hi);
  assign trials_done = wake_en[icwc_pkg::WB_TIMEOUT]
                     && (trial_cnt == trial_lim[icwc_pkg::TRIAL_BITS-1:0]);

  icwc_slow_timer #(
    .W (icwc_pkg::TMR_W)
  ) u_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .tick     (lfo_tick),
    .expired  (tmr_done)
  );

  // Frame parse, wake sequencing, reply and registers
  always_comb begin
    next_state      = state;
    next_idx        = idx;
    next_len        = len;
    next_have_len   = have_len;
    next_err_flag   = err_flag;
    next_frame_buf  = frame_buf;
    next_wake_en    = wake_en;
    next_wake_src   = wake_src;
    next_enter_word = enter_word;
    next_wait_word  = wait_word;
    next_leave_word = leave_word;
    next_interval   = interval;
    next_osc_start  = osc_start;
    next_dac_start  = dac_start;
    next_cmp_lo     = cmp_lo;
    next_cmp_hi     = cmp_hi;
    next_swing_lim  = swing_lim;
    next_trial_lim  = trial_lim;
    next_swing_cnt  = swing_cnt;
    next_trial_cnt  = trial_cnt;
    next_res_word   = res_word;
    next_rsp_byte   = rsp_byte;
    next_rsp_idx    = rsp_idx;
    tmr_load        = 1'b0;
    tmr_val         = ivl_ticks(interval);
    next_rdata      = 32'h00000000;
    if (reg_wr && (reg_addr == icwc_pkg::REG_WAKE_EN)) begin
      next_wake_en = reg_wdata[4:0];
    end
    unique case (state)
      icwc_pkg::ST_READY: begin
        if (cmd_valid && (cmd_byte == icwc_pkg::IDLE_CODE)) begin
          next_state    = icwc_pkg::ST_RECV;
          next_idx      = 8'h00;
          next_have_len = 1'b0;
        end
      end
      icwc_pkg::ST_RECV: begin
        if (cmd_valid && !have_len) begin
          next_len      = cmd_byte;
          next_have_len = 1'b1;
          if (cmd_byte == 8'h00) begin
            next_err_flag = 1'b1;
            next_rsp_idx  = 8'h00;
            next_rsp_byte = icwc_pkg::RSP_ERR;
            next_state    = icwc_pkg::ST_LEAVE;
          end
        end else if (cmd_valid) begin
          if (idx < 8'(NB)) begin
            next_frame_buf[idx[3:0]] = cmd_byte;
          end
          next_idx = idx + 8'h01;
        end
        if (frame_end && (len == icwc_pkg::FRAME_LEN)) begin
          next_wake_en    = next_frame_buf[icwc_pkg::P_WAKE][4:0];
          next_enter_word = {next_frame_buf[icwc_pkg::P_ENTER_0],
                             next_frame_buf[icwc_pkg::P_ENTER_1]};
          next_wait_word  = {next_frame_buf[icwc_pkg::P_WAIT_0],
                             next_frame_buf[icwc_pkg::P_WAIT_1]};
          next_leave_word = {next_frame_buf[icwc_pkg::P_LEAVE_0],
                             next_frame_buf[icwc_pkg::P_LEAVE_1]};
          next_interval   = next_frame_buf[icwc_pkg::P_INTERVAL];
          next_osc_start  = next_frame_buf[icwc_pkg::P_OSC];
          next_dac_start  = next_frame_buf[icwc_pkg::P_DAC];
          next_cmp_lo     = next_frame_buf[icwc_pkg::P_CMP_LO];
          next_cmp_hi     = next_frame_buf[icwc_pkg::P_CMP_HI];
          next_swing_lim  = next_frame_buf[icwc_pkg::P_SWING];
          next_trial_lim  = next_frame_buf[icwc_pkg::P_TRIAL];
          next_res_word   = {next_frame_buf[icwc_pkg::P_ENTER_0],
                             next_frame_buf[icwc_pkg::P_ENTER_1]};
          next_err_flag   = 1'b0;
          next_trial_cnt  = 5'h00;
          next_state      = icwc_pkg::ST_ENTER;
        end else if (frame_end) begin
          next_err_flag = 1'b1;
          next_rsp_idx  = 8'h00;
          next_rsp_byte = icwc_pkg::RSP_ERR;
          next_state    = icwc_pkg::ST_LEAVE;
        end
      end
      icwc_pkg::ST_ENTER: begin
        tmr_load      = 1'b1;
        next_res_word = wait_word;
        next_state    = icwc_pkg::ST_SLEEP;
      end
      icwc_pkg::ST_SLEEP: begin
        if (tmr_done && wake_en[icwc_pkg::WB_TAG]) begin
          tmr_load   = 1'b1;
          tmr_val    = {9'h000, osc_start};
          next_state = icwc_pkg::ST_OSC;
        end else if (tmr_done && wake_en[icwc_pkg::WB_TIMEOUT] && !trials_done) begin
          tmr_load       = 1'b1;
          next_trial_cnt = trial_cnt + 5'h01;
        end
      end
      icwc_pkg::ST_OSC: begin
        if (tmr_done) begin
          tmr_load   = 1'b1;
          tmr_val    = {9'h000, dac_start};
          next_state = icwc_pkg::ST_DAC;
        end
      end
      icwc_pkg::ST_DAC: begin
        if (tmr_done) begin
          next_swing_cnt = 8'h00;
          next_state     = icwc_pkg::ST_BURST;
        end
      end
      icwc_pkg::ST_BURST: begin
        if (swing_pulse && (swing_cnt < swing_lim)) begin
          next_swing_cnt = swing_cnt + 8'h01;
        end
        if (swing_cnt >= swing_lim) begin
          next_state = icwc_pkg::ST_SLEEP;
          tmr_load   = 1'b1;
          if (!trials_done) begin
            next_trial_cnt = trial_cnt + 5'h01;
          end
        end
      end
      icwc_pkg::ST_LEAVE: begin
        if (rsp_ready) begin
          next_rsp_idx  = rsp_idx + 8'h01;
          next_rsp_byte = rsp_pick(err_flag, rsp_idx + 8'h01, wake_src);
          if (rsp_idx == (err_flag ? 8'h01 : 8'h02)) begin
            next_state    = icwc_pkg::ST_READY;
            next_res_word = icwc_pkg::WORD_RST;
          end
        end
      end
    endcase
    // Wake decision, external sources first
    if (wait_mode && (state != icwc_pkg::ST_ENTER)) begin
      if (ext_hit) begin
        next_wake_src = ext_src;
      end else if ((state == icwc_pkg::ST_BURST) && (swing_cnt >= swing_lim)
                   && tag_seen) begin
        next_wake_src = 5'h02;
      end else if (tmr_done && trials_done && ((state == icwc_pkg::ST_SLEEP)
                   || ((state == icwc_pkg::ST_BURST) && (swing_cnt >= swing_lim)))) begin
        next_wake_src = 5'h01;
      end
      if (next_wake_src != wake_src || ext_hit || next_state == state
          || state == icwc_pkg::ST_BURST) begin
        if (ext_hit || (next_wake_src != wake_src)
            || ((state == icwc_pkg::ST_BURST) && (swing_cnt >= swing_lim) && tag_seen)
            || (tmr_done && trials_done && ((state == icwc_pkg::ST_SLEEP)
                || ((state == icwc_pkg::ST_BURST) && (swing_cnt >= swing_lim))))) begin
          next_state    = icwc_pkg::ST_LEAVE;
          next_err_flag = 1'b0;
          next_rsp_idx  = 8'h00;
          next_rsp_byte = icwc_pkg::RSP_OK;
          next_res_word = leave_word;
          tmr_load      = 1'b0;
        end
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        icwc_pkg::REG_STATUS:  next_rdata = {19'h00000, wake_src, 4'h0, wait_mode, state};
        icwc_pkg::REG_WAKE_EN: next_rdata = {27'h0000000, wake_en};
        icwc_pkg::REG_THRESH:  next_rdata = {trial_lim, swing_lim, cmp_hi, cmp_lo};
        icwc_pkg::REG_TIMING:  next_rdata = {8'h00, dac_start, osc_start, interval};
        default:               next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state      <= icwc_pkg::ST_READY;
      idx        <= icwc_pkg::BYTE_RST;
      len        <= icwc_pkg::BYTE_RST;
      have_len   <= 1'b0;
      err_flag   <= 1'b0;
      frame_buf  <= '{default: icwc_pkg::BYTE_RST};
      wake_en    <= icwc_pkg::WAKE_RST;
      wake_src   <= icwc_pkg::WAKE_RST;
      enter_word <= icwc_pkg::WORD_RST;
      wait_word  <= icwc_pkg::WORD_RST;
      leave_word <= icwc_pkg::WORD_RST;
      interval   <= icwc_pkg::BYTE_RST;
      osc_start  <= icwc_pkg::BYTE_RST;
      dac_start  <= icwc_pkg::BYTE_RST;
      cmp_lo     <= icwc_pkg::BYTE_RST;
      cmp_hi     <= icwc_pkg::BYTE_RST;
      swing_lim  <= icwc_pkg::BYTE_RST;
      trial_lim  <= icwc_pkg::BYTE_RST;
      swing_cnt  <= icwc_pkg::BYTE_RST;
      trial_cnt  <= 5'h00;
      res_word   <= icwc_pkg::WORD_RST;
      rsp_byte   <= icwc_pkg::BYTE_RST;
      rsp_idx    <= icwc_pkg::BYTE_RST;
      reg_rdata  <= 32'h00000000;
    end else begin
      state      <= next_state;
      idx        <= next_idx;
      len        <= next_len;
      have_len   <= next_have_len;
      err_flag   <= next_err_flag;
      frame_buf  <= next_frame_buf;
      wake_en    <= next_wake_en;
      wake_src   <= next_wake_src;
      enter_word <= next_enter_word;
      wait_word  <= next_wait_word;
      leave_word <= next_leave_word;
      interval   <= next_interval;
      osc_start  <= next_osc_start;
      dac_start  <= next_dac_start;
      cmp_lo     <= next_cmp_lo;
      cmp_hi     <= next_cmp_hi;
      swing_lim  <= next_swing_lim;
      trial_lim  <= next_trial_lim;
      swing_cnt  <= next_swing_cnt;
      trial_cnt  <= next_trial_cnt;
      res_word   <= next_res_word;
      rsp_byte   <= next_rsp_byte;
      rsp_idx    <= next_rsp_idx;
      reg_rdata  <= next_rdata;
    end
  end

  // Mode and resource enables
  assign wait_mode  = (state == icwc_pkg::ST_ENTER) || (state == icwc_pkg::ST_SLEEP)
                   || (state == icwc_pkg::ST_OSC) || (state == icwc_pkg::ST_DAC)
                   || (state == icwc_pkg::ST_BURST);
  assign hfo_enable = (state == icwc_pkg::ST_OSC) || (state == icwc_pkg::ST_DAC)
                   || (state == icwc_pkg::ST_BURST);
  assign dac_enable = (state == icwc_pkg::ST_DAC) || (state == icwc_pkg::ST_BURST);
  assign burst_on   = (state == icwc_pkg::ST_BURST);
  assign rsp_valid  = (state == icwc_pkg::ST_LEAVE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_hdr_taken;
    rsp_valid && rsp_ready && (rsp_idx == 8'h00) && !err_flag;
  endsequence
  sequence s_len_shown;
    rsp_valid && (rsp_byte == icwc_pkg::RSP_LEN1);
  endsequence

  idle_code_entry_a: assert property (
    (state == icwc_pkg::ST_READY) && cmd_valid && (cmd_byte == icwc_pkg::IDLE_CODE)
    |=> state == icwc_pkg::ST_RECV) else $error("idle code not taken");
  frame_latch_a: assert property (
    (state == icwc_pkg::ST_RECV) && frame_end && (len == icwc_pkg::FRAME_LEN)
    |=> (state == icwc_pkg::ST_ENTER) && (res_word == enter_word))
    else $error("full frame did not enter");
  length_err_a: assert property (
    (state == icwc_pkg::ST_RECV) && frame_end && (len != icwc_pkg::FRAME_LEN)
    |=> err_flag && (rsp_byte == icwc_pkg::RSP_ERR)) else $error("bad length accepted");
  wake_load_a: assert property (
    state == icwc_pkg::ST_ENTER |-> wake_en == frame_buf[icwc_pkg::P_WAKE][4:0])
    else $error("wake enables not loaded");
  interval_load_a: assert property (
    (state == icwc_pkg::ST_ENTER) |-> tmr_load && (tmr_val == ivl_ticks(interval)))
    else $error("interval wait wrong");
  osc_settle_a: assert property (
    (state == icwc_pkg::ST_OSC) && !tmr_done |=> state != icwc_pkg::ST_DAC)
    else $error("oscillator wait cut short");
  dac_settle_a: assert property (
    (state == icwc_pkg::ST_DAC) && !tmr_done |=> state != icwc_pkg::ST_BURST)
    else $error("converter wait cut short");
  burst_limit_a: assert property (
    burst_on |-> swing_cnt <= swing_lim) else $error("burst swings exceeded");
  timeout_src_a: assert property (
    (state != icwc_pkg::ST_LEAVE) ##1 (state == icwc_pkg::ST_LEAVE) && !err_flag
    && (wake_src == 5'h01) |-> $past(trials_done)) else $error("early timeout");
  reply_len_a: assert property (s_hdr_taken |=> s_len_shown)
    else $error("reply length byte wrong");
endmodule
`default_nettype wire

//--- verilog/icwc_pkg.sv
// Constants, field layout and state encoding of the idle command wake controller
`default_nettype none
package icwc_pkg;
  // Frame codes
  localparam logic [7:0] IDLE_CODE   = 8'h07;
  localparam logic [7:0] FRAME_LEN   = 8'h0E;
  localparam int         PARAM_BYTES = 14;
  // Parameter byte positions after the length byte
  localparam int P_WAKE     = 0;
  localparam int P_ENTER_0  = 1;
  localparam int P_ENTER_1  = 2;
  localparam int P_WAIT_0   = 3;
  localparam int P_WAIT_1   = 4;
  localparam int P_LEAVE_0  = 5;
  localparam int P_LEAVE_1  = 6;
  localparam int P_INTERVAL = 7;
  localparam int P_OSC      = 8;
  localparam int P_DAC      = 9;
  localparam int P_CMP_LO   = 10;
  localparam int P_CMP_HI   = 11;
  localparam int P_SWING    = 12;
  localparam int P_TRIAL    = 13;
  // Wake source bit positions
  localparam int WB_TIMEOUT = 0;
  localparam int WB_TAG     = 1;
  localparam int WB_FIELD   = 2;
  localparam int WB_IRQ     = 3;
  localparam int WB_SEL     = 4;
  localparam int WAKE_W     = 5;
  localparam int TRIAL_BITS = 5;
  // Slow timing: 256 slow periods per reference, interval offset of 2
  localparam int         TMR_W       = 17;
  localparam logic [7:0] REF_LOW     = 8'h00;
  localparam logic [8:0] IVL_OFFSET  = 9'h002;
  // Reply bytes
  localparam logic [7:0] RSP_OK   = 8'h00;
  localparam logic [7:0] RSP_LEN1 = 8'h01;
  localparam logic [7:0] RSP_ERR  = 8'h82;
  localparam logic [7:0] RSP_LEN0 = 8'h00;
  // Register byte offsets
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_WAKE_EN = 8'h04;
  localparam logic [7:0] REG_THRESH  = 8'h08;
  localparam logic [7:0] REG_TIMING  = 8'h0C;
  // Values after reset
  localparam logic [4:0]  WAKE_RST = 5'h00;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // Controller states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_READY = 3'h0,
    ST_RECV  = 3'h1,
    ST_ENTER = 3'h3,
    ST_SLEEP = 3'h2,
    ST_OSC   = 3'h6,
    ST_DAC   = 3'h7,
    ST_BURST = 3'h5,
    ST_LEAVE = 3'h4
  } icwc_state_t;
endpackage
`default_nettype wire

//--- verilog/icwc_slow_timer.sv
// Slow-clock down counter for interval and settle waits
`timescale 1ns/10ps
`default_nettype none
module icwc_slow_timer #(
  parameter int W = 17  // Counter width in bits, counts slow-clock periods
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic         load,      // Start a new wait
  input  wire logic [W-1:0] load_val,  // Wait length in slow periods
  input  wire logic         tick,      // One slow period elapsed
  output logic              expired    // Count has reached zero
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // Reload, or count down once per slow period
  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = load_val;
    end else if (tick && (cnt != '0)) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired = (cnt == '0);

  // Count only falls on a tick unless reloaded
  tick_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !load && !tick |=> cnt == $past(cnt))
    else $error("slow timer moved without tick");
endmodule
`default_nettype wire

//--- sim/icwc_host_model.sv
// Host controller model: sends command bytes, takes reply bytes
`timescale 1ns/10ps
`default_nettype none
module icwc_host_model (
  input  wire logic       clk_sys,    // System clock
  output logic [7:0]      cmd_byte,   // Command byte
  output logic            cmd_valid,  // Command strobe
  input  wire logic [7:0] rsp_byte,   // Reply byte
  input  wire logic       rsp_valid,  // Reply available
  output logic            rsp_ready   // Taken, every other cycle
);
  logic [7:0] got[$];
  initial cmd_byte = 8'h00;
  initial cmd_valid = 1'b0;
  initial rsp_ready = 1'b0;
  // Slow taker, bytes logged when taken
  always @(posedge clk_sys) begin
    rsp_ready <= ~rsp_ready;
    if (rsp_valid && rsp_ready)
      got.push_back(rsp_byte);
  end
  // Whole frame back to back, then the line shows the inverse
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_byte  <= b[i];
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_byte  <= ~b[b.size()-1];
    #1;
  endtask
endmodule
`default_nettype wire

//--- sim/icwc_idle_ctrl_tb_top.sv
// Testbench: idle frames, wakes, timeout, bad length, registers
`timescale 1ns/10ps
`default_nettype none
module icwc_idle_ctrl_tb_top;
  localparam int TO_CYC = 256 * (0 + 2) * ((8'h21 & 8'h1F) + 1) * 4;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        low_freq_oscillator = 1'b0;
  logic        field = 1'b0;
  logic        irq_n = 1'b1;
  logic        sel_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        swing = 1'b0;
  logic [7:0]  dac = 8'h00;
  logic        high_freq_oscillator, dacen, burst;
  logic [7:0]  cmd_byte, rsp_byte;
  logic        cmd_valid, rsp_valid, rsp_ready, wait_mode;
  logic [15:0] res_word;
  logic [31:0] reg_rdata;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  icwc_host_model host (.clk_sys(clk_sys), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));
  icwc_idle_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .lfo_clk_pin(low_freq_oscillator), .field_det_pin(field), .irq_in_n(irq_n), .sel_n(sel_n),
    .dac_level(dac), .swing_pulse(swing), .wait_mode(wait_mode), .hfo_enable(high_freq_oscillator),
    .dac_enable(dacen), .burst_on(burst), .res_word(res_word), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Clock, slow clock of four periods, run limit
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    low_freq_oscillator <= cyc[1];
    swing <= cyc[0];
    if (cyc == 60000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "reg read");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Bounded wait until n reply bytes were taken
  task automatic wait_reply(input int n, output int t);
    t = 0;
    while (host.got.size() < n && t < 20000) begin
      @(posedge clk_sys);
      t++;
    end
    #1;
  endtask
  // External wake: frame, settings, pin event, reply, back to ready
  task automatic t_wake(input logic [7:0] src, input logic [15:0] e);
    int t;
    host.got.delete();
    host.send({8'h07, 8'h0E, src, e[15:8], e[7:0], 8'h38, 8'h00, 8'h18, 8'h00,
      8'h20, 8'h60, 8'h61, 8'h64, 8'h74, 8'h3F, 8'h08});
    chk({wait_mode, res_word}, {1'b1, e}, "enter word");
    @(posedge clk_sys);
    #1;
    chk(res_word, 16'h3800, "wait word");
    rd(icwc_pkg::REG_WAKE_EN, {27'h0, src[4:0]});
    rd(icwc_pkg::REG_THRESH, 32'h083F7464);
    rd(icwc_pkg::REG_TIMING, 32'h00616020);
    rd(8'h10, 32'h0);
    irq_n <= ~src[3];
    sel_n <= ~src[4];
    field <= src[2];
    repeat (4) @(posedge clk_sys);
    irq_n <= 1'b1;
    sel_n <= 1'b1;
    wait_reply(1, t);
    chk(res_word, 16'h1800, "leave word");
    wait_reply(3, t);
    field <= 1'b0;
    chk({host.got[0], host.got[1], host.got[2]}, {8'h00, 8'h01, src}, "reply");
    repeat (3) @(posedge clk_sys);
    chk({wait_mode, res_word}, 17'h0, "back ready");
  endtask
  // Length byte zero: error reply, no mode change
  task automatic t_badlen();
    int t;
    host.got.delete();
    host.send({8'h07, 8'h00});
    wait_reply(2, t);
    chk({host.got[0], host.got[1], wait_mode}, {8'h82, 8'h00, 1'b0}, "bad length");
  endtask
  // Timer wake; trial byte above range checks the five-bit reading
  task automatic t_timeout();
    int t;
    host.got.delete();
    host.send({8'h07, 8'h0E, 8'h01, 8'h21, 8'h00, 8'h38, 8'h00, 8'h18, 8'h00,
      8'h00, 8'h60, 8'h60, 8'h00, 8'h00, 8'h00, 8'h21});
    wait_reply(1, t);
    chk(t >= TO_CYC - 6 && t <= TO_CYC + 24, 1'b1, "timeout length");
    wait_reply(3, t);
    chk(host.got[2], 8'h01, "timeout source");
  endtask
  // Calibration frame: bursts, then tag wake or timeout after two trials
  task automatic t_tag(input logic [7:0] lvl, input logic [7:0] exp);
    int t;
    host.got.delete();
    dac <= lvl;
    host.send({8'h07, 8'h0E, 8'h03, 8'hA2, 8'h00, 8'hF8, 8'h01, 8'h18, 8'h00,
      8'h00, 8'h02, 8'h02, 8'h00, 8'h20, 8'h03, 8'h01});
    t = 0;
    while (!burst && t < 20000) begin
      @(posedge clk_sys);
      t++;
    end
    #1;
    chk({high_freq_oscillator, dacen, burst}, 3'b111, "burst enables");
    wait_reply(3, t);
    chk(host.got[2], exp, "tag source");
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    host.send({8'h55});
    chk({wait_mode, rsp_valid}, 2'b00, "stray byte");
    wr(icwc_pkg::REG_WAKE_EN, 32'h13);
    rd(icwc_pkg::REG_WAKE_EN, 32'h13);
    t_wake(8'h08, 16'h0100);
    t_wake(8'h10, 16'h0100);
    t_wake(8'h04, 16'h0142);
    t_badlen();
    t_timeout();
    t_tag(8'h10, 8'h01);
    t_tag(8'h80, 8'h02);
    final_report();
  end
endmodule
`default_nettype wire
